// ===== cfd_core.sv
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

// Behaviour
// - after reset only interrupt-disable is defined, as 1; rest held 0.
// - push-flags stores flag word so it reads back at stack pointer plus one.
// - with D at 1, only add and subtract with carry give decimal results.
// - N, V and Z carry no meaning after decimal arithmetic.
// - decimal carry is 1 on carry, 0 on borrow.
// - break vectors via the top-priority requested, enabled source while interrupt-disable is 1; otherwise via the plain break vector.
// - product and quotient ignore the X-mode and decimal flags.
// - product and quotient leave the flag word unchanged.
// - read-modify-write reads a byte, modifies, writes back same address.
// - RMW: bit ops, shifts, rotates, nibble rotate, inc, dec, complement.
// - with X-mode 1, add, subtract and logic ops become RMW on memory.
module cfd_core
    import cfd_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // operation request
    input wire cfd_pkg::cfd_op_req_s opReq,
    input wire logic opValid,
    output logic opReady,
    output logic opDone,
    // memory port, read data one cycle after the read strobe
    output cfd_pkg::cfd_mem_cmd_s memCmd,
    input wire logic [7:0] memRdata,
    // interrupt sources
    input wire logic [cfd_pkg::NUM_SRC-1:0] srcReq,
    input wire logic [cfd_pkg::NUM_SRC-1:0] srcEn,
    output logic [15:0] breakVector,
    output logic breakTaken,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    // core state
    output logic [7:0] flagsWord,
    output logic [7:0] stackPtr,
    output logic [7:0] accum,
    output logic [7:0] idxX
);
    import cfd_pkg::*;

    cfd_state_e stateQ;
    cfd_op_req_s opQ;
    cfd_mem_cmd_s memQ;
    logic memOpQ;
    logic doneQ;
    logic [7:0] flagsQ;
    logic [7:0] spQ;
    logic [7:0] accQ;
    logic [7:0] idxQ;
    logic [7:0] vecHiQ;
    logic [15:0] vecQ;
    logic takenQ;
    logic [7:0] regRdataQ;
    logic accept;
    logic aluOp;
    logic rmwOp;
    logic needRead;
    logic [15:0] readAddr;
    logic [7:0] aluSrc;
    logic [7:0] aluRes;
    logic [7:0] aluFlags;
    logic [15:0] product;
    logic [7:0] quotLo;
    logic [7:0] quotRem;
    logic [NUM_SRC-1:0] pending;
    logic [7:0] selLow;

    // packed-decimal adders; carry out in bit 8
    function automatic logic [8:0] bcdAdd(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
        if (lo > 5'h09) lo = lo + 5'h06;
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09) hi = hi + 5'h06;
        return {hi[4], hi[3:0], lo[3:0]};
    endfunction : bcdAdd

    function automatic logic [8:0] bcdSub(input logic [7:0] a,
                                          input logic [7:0] b,
                                          input logic c);
        logic [4:0] lo;
        logic [4:0] hi;
        logic bl;
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~c};
        bl = lo[4];
        if (bl) lo = lo - 5'h06;
        hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, bl};
        // carry set means no borrow
        return {~hi[4], hi[4] ? hi[3:0] - 4'h6 : hi[3:0], lo[3:0]};
    endfunction : bcdSub

    // operation classes
    assign aluOp = opReq.code inside {OP_ADD_CARRY, OP_SUB_BORROW, OP_AND,
                                      OP_XOR, OP_IOR};
    assign rmwOp = opReq.code inside {OP_BIT_SET, OP_BIT_CLEAR,
        OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_ROT_LEFT, OP_ROT_RIGHT,
        OP_NIBBLE_ROT, OP_ADD_ONE, OP_SUB_ONE, OP_COMPLEMENT};
    assign needRead = rmwOp || (aluOp && flagsQ[FLAG_T]) ||
                      opReq.code == OP_PULL_FLAGS;
    assign opReady = stateQ == ST_IDLE;
    assign accept = opReady && opValid;

    // read target: X-indexed byte replaces the accumulator in X mode
    always_comb begin
        if (opReq.code == OP_PULL_FLAGS) begin
            readAddr = {STACK_PAGE, spQ + 8'h01};
        end else if (aluOp) begin
            readAddr = {ZERO_PAGE, idxQ};
        end else begin
            readAddr = {ZERO_PAGE, opReq.addr};
        end
    end

    // highest-priority requested and enabled source while I is set, lowest index first
    assign pending = srcReq & srcEn;
    always_comb begin
        selLow = VEC_LOW_BREAK;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i] && flagsQ[FLAG_I]) begin
                selLow = VEC_LOW_TOP - 8'(2 * i);
            end
        end
    end

    // product and quotient use plain binary, independent of T and D
    assign product = 16'(accQ) * 16'(opQ.data);
    assign quotLo = (opQ.data == 8'h00) ? 8'hFF : accQ / opQ.data;
    assign quotRem = (opQ.data == 8'h00) ? accQ : accQ % opQ.data;

    // data path for the modify step
    always_comb begin
        logic [8:0] sum;
        logic nz;
        sum = 9'h000;
        nz = 1'b0;
        aluSrc = memOpQ ? memRdata : accQ;
        aluRes = aluSrc;
        aluFlags = flagsQ;
        unique case (opQ.code)
            OP_ADD_CARRY: begin
                if (flagsQ[FLAG_D]) begin
                    sum = bcdAdd(aluSrc, opQ.data, flagsQ[FLAG_C]);
                end else begin
                    sum = {1'b0, aluSrc} + {1'b0, opQ.data} +
                          {8'h00, flagsQ[FLAG_C]};
                end
                aluRes = sum[7:0];
                aluFlags[FLAG_C] = sum[8];
                aluFlags[FLAG_V] = (aluSrc[7] == opQ.data[7]) &&
                                   (sum[7] != aluSrc[7]);
                nz = 1'b1;
            end
            OP_SUB_BORROW: begin
                if (flagsQ[FLAG_D]) begin
                    sum = bcdSub(aluSrc, opQ.data, flagsQ[FLAG_C]);
                end else begin
                    sum = {1'b0, aluSrc} + {1'b0, ~opQ.data} +
                          {8'h00, flagsQ[FLAG_C]};
                end
                aluRes = sum[7:0];
                aluFlags[FLAG_C] = sum[8];
                aluFlags[FLAG_V] = (aluSrc[7] != opQ.data[7]) &&
                                   (sum[7] != aluSrc[7]);
                nz = 1'b1;
            end
            OP_AND: begin
                aluRes = aluSrc & opQ.data;
                nz = 1'b1;
            end
            OP_XOR: begin
                aluRes = aluSrc ^ opQ.data;
                nz = 1'b1;
            end
            OP_IOR: begin
                aluRes = aluSrc | opQ.data;
                nz = 1'b1;
            end
            OP_BIT_SET: aluRes = aluSrc | (8'h01 << opQ.bitSel);
            OP_BIT_CLEAR: aluRes = aluSrc & ~(8'h01 << opQ.bitSel);
            OP_SHIFT_LEFT: begin
                {aluFlags[FLAG_C], aluRes} = {aluSrc, 1'b0};
                nz = 1'b1;
            end
            OP_SHIFT_RIGHT: begin
                {aluRes, aluFlags[FLAG_C]} = {1'b0, aluSrc};
                nz = 1'b1;
            end
            OP_ROT_LEFT: begin
                {aluFlags[FLAG_C], aluRes} = {aluSrc, flagsQ[FLAG_C]};
                nz = 1'b1;
            end
            OP_ROT_RIGHT: begin
                {aluRes, aluFlags[FLAG_C]} = {flagsQ[FLAG_C], aluSrc};
                nz = 1'b1;
            end
            OP_NIBBLE_ROT: aluRes = {aluSrc[3:0], aluSrc[7:4]};
            OP_ADD_ONE: begin
                aluRes = aluSrc + 8'h01;
                nz = 1'b1;
            end
            OP_SUB_ONE: begin
                aluRes = aluSrc - 8'h01;
                nz = 1'b1;
            end
            OP_COMPLEMENT: begin
                aluRes = ~aluSrc;
                nz = 1'b1;
            end
            OP_PULL_FLAGS: aluFlags = memRdata;
            OP_CARRY_SET: aluFlags[FLAG_C] = 1'b1;
            OP_CARRY_CLEAR: aluFlags[FLAG_C] = 1'b0;
            OP_DECIMAL_ON: aluFlags[FLAG_D] = 1'b1;
            OP_DECIMAL_OFF: aluFlags[FLAG_D] = 1'b0;
            OP_XMODE_ON: aluFlags[FLAG_T] = 1'b1;
            OP_XMODE_OFF: aluFlags[FLAG_T] = 1'b0;
            OP_LOAD_ACC, OP_LOAD_IDX: begin
                aluRes = opQ.data;
                nz = 1'b1;
            end
            OP_PUSH_FLAGS, OP_PRODUCT, OP_QUOTIENT, OP_SW_BREAK,
            OP_IDLE: aluFlags = flagsQ;
            default: aluFlags = flagsQ;
        endcase
        if (nz) begin
            aluFlags[FLAG_N] = aluRes[7];
            aluFlags[FLAG_Z] = aluRes == 8'h00;
        end
    end

    // sequencer: accept, read, modify, write back
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= ST_IDLE;
            opQ <= '0;
            memOpQ <= 1'b0;
            doneQ <= 1'b0;
        end else begin
            doneQ <= 1'b0;
            unique case (stateQ)
                ST_IDLE: begin
                    if (accept) begin
                        opQ <= opReq;
                        memOpQ <= needRead;
                        if (needRead) begin
                            stateQ <= ST_READ;
                        end else if (opReq.code inside {OP_PUSH_FLAGS,
                                                        OP_SW_BREAK}) begin
                            stateQ <= ST_WRITE;
                        end else begin
                            stateQ <= ST_MODIFY;
                        end
                    end
                end
                ST_READ: stateQ <= ST_MODIFY;
                ST_MODIFY: begin
                    // only memory-sourced ops other than pull write back
                    if (memOpQ && opQ.code != OP_PULL_FLAGS) begin
                        stateQ <= ST_WRITE;
                    end else begin
                        stateQ <= ST_IDLE;
                        doneQ <= 1'b1;
                    end
                end
                ST_WRITE: begin
                    stateQ <= ST_IDLE;
                    doneQ <= 1'b1;
                end
            endcase
        end
    end

    // memory strobes, one cycle each; write-back reuses the read address
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            memQ <= '0;
        end else begin
            memQ.rd <= 1'b0;
            memQ.wr <= 1'b0;
            if (accept && needRead) begin
                memQ.rd <= 1'b1;
                memQ.addr <= readAddr;
            end else if (accept && opReq.code inside {OP_PUSH_FLAGS,
                                                      OP_SW_BREAK}) begin
                memQ.wr <= 1'b1;
                memQ.addr <= {STACK_PAGE, spQ};
                memQ.wdata <= flagsQ |
                    ((opReq.code == OP_SW_BREAK) ? 8'(1 << FLAG_B) : 8'h00);
            end else if (stateQ == ST_MODIFY && memOpQ &&
                         opQ.code != OP_PULL_FLAGS) begin
                memQ.wr <= 1'b1;
                memQ.wdata <= aluRes;
            end
        end
    end

    // stack pointer: post-decrement on push, pre-increment on pull
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            spQ <= SP_RST;
        end else if (accept && opReq.code inside {OP_PUSH_FLAGS,
                                                  OP_SW_BREAK}) begin
            spQ <= spQ - 8'h01;
        end else if (accept && opReq.code == OP_PULL_FLAGS) begin
            spQ <= spQ + 8'h01;
        end
    end

    // flag word; break masks further interrupts after stacking
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flagsQ <= FLAGS_RST;
        end else if (accept && opReq.code == OP_SW_BREAK) begin
            flagsQ[FLAG_I] <= 1'b1;
        end else if (stateQ == ST_MODIFY) begin
            flagsQ <= aluFlags;
        end
    end

    // accumulator and index; memory destinations leave them alone
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            accQ <= 8'h00;
            idxQ <= 8'h00;
        end else if (stateQ == ST_MODIFY) begin
            unique case (opQ.code)
                OP_PRODUCT: {idxQ, accQ} <= product;
                OP_QUOTIENT: begin
                    accQ <= quotLo;
                    idxQ <= quotRem;
                end
                OP_LOAD_IDX: idxQ <= aluRes;
                OP_LOAD_ACC: accQ <= aluRes;
                OP_ADD_CARRY, OP_SUB_BORROW, OP_AND, OP_XOR,
                OP_IOR: if (!memOpQ) accQ <= aluRes;
                default: accQ <= accQ;
            endcase
        end
    end

    // break vector, latched when the break is taken
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vecQ <= 16'h0000;
            takenQ <= 1'b0;
        end else begin
            takenQ <= accept && opReq.code == OP_SW_BREAK;
            if (accept && opReq.code == OP_SW_BREAK) begin
                vecQ <= {vecHiQ, selLow};
            end
        end
    end

    // register port; unmapped offsets read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vecHiQ <= VEC_HI_RST;
            regRdataQ <= 8'h00;
        end else begin
            if (regWr && regAddr == REG_VEC) begin
                vecHiQ <= regWdata;
            end
            if (regRd) begin
                unique case (regAddr)
                    REG_FLAGS: regRdataQ <= flagsQ;
                    REG_SP: regRdataQ <= spQ;
                    REG_ACC: regRdataQ <= accQ;
                    REG_IDX: regRdataQ <= idxQ;
                    REG_VEC: regRdataQ <= vecHiQ;
                    default: regRdataQ <= 8'h00;
                endcase
            end
        end
    end

    assign opDone = doneQ;
    assign memCmd = memQ;
    assign breakVector = vecQ;
    assign breakTaken = takenQ;
    assign regRdata = regRdataQ;
    assign flagsWord = flagsQ;
    assign stackPtr = spQ;
    assign accum = accQ;
    assign idxX = idxQ;

    // assertion helpers
    logic anyOpQ;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) anyOpQ <= 1'b0;
        else if (accept) anyOpQ <= 1'b1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_reset_iflag: assert property (!anyOpQ |-> flagsQ[FLAG_I])
        else $error("interrupt disable not set after reset");
    chk_push_slot: assert property (
        accept && opReq.code == OP_PUSH_FLAGS
        |=> memQ.wr && memQ.addr == {STACK_PAGE, spQ + 8'h01} &&
            memQ.wdata == flagsQ)
        else $error("pushed flags not at stack pointer plus one");
    chk_bcd_digits: assert property (stateQ == ST_MODIFY &&
        opQ.code == OP_ADD_CARRY && flagsQ[FLAG_D] &&
        aluSrc[3:0] < 4'hA && aluSrc[7:4] < 4'hA &&
        opQ.data[3:0] < 4'hA && opQ.data[7:4] < 4'hA
        |-> aluRes[3:0] < 4'hA && aluRes[7:4] < 4'hA)
        else $error("decimal add gave a non-decimal digit");
    chk_bcd_borrow: assert property (stateQ == ST_MODIFY &&
        opQ.code == OP_SUB_BORROW && flagsQ[FLAG_D]
        |=> flagsQ[FLAG_C] == ({1'b0, $past(aluSrc)} >=
            {1'b0, $past(opQ.data)} + {8'h00, ~$past(flagsQ[FLAG_C])}))
        else $error("decimal subtract carry does not match borrow");
    chk_product_val: assert property (stateQ == ST_MODIFY &&
        opQ.code == OP_PRODUCT
        |=> {idxQ, accQ} == 16'($past(accQ)) * 16'($past(opQ.data)))
        else $error("product wrong");
    chk_muldiv_flags: assert property (stateQ == ST_MODIFY &&
        opQ.code inside {OP_PRODUCT, OP_QUOTIENT} |=> $stable(flagsQ))
        else $error("product or quotient changed the flags");
    chk_rmw_writeback: assert property (memQ.rd && opQ.code inside
        {OP_BIT_SET, OP_SHIFT_LEFT, OP_ADD_ONE, OP_COMPLEMENT}
        |-> ##2 memQ.wr && memQ.addr == $past(memQ.addr, 2))
        else $error("write-back missing or to another address");
    chk_xmode_dest: assert property (accept && aluOp && flagsQ[FLAG_T]
        |=> memQ.rd && memQ.addr == {ZERO_PAGE, idxQ} ##3 $stable(accQ))
        else $error("x mode did not target memory at X");
    chk_break_vec: assert property (
        accept && opReq.code == OP_SW_BREAK &&
        pending[0] && flagsQ[FLAG_I]
        |=> breakTaken && breakVector == {vecHiQ, VEC_LOW_TOP})
        else $error("break not vectored to top-priority source");
    chk_pull_sp: assert property (accept && opReq.code == OP_PULL_FLAGS
        |=> memQ.rd && memQ.addr == {STACK_PAGE, spQ} ##2
            flagsQ == $past(memRdata))
        else $error("pull read wrong slot or not restored");

    cov_decimal_add: cover property (stateQ == ST_MODIFY &&
        opQ.code == OP_ADD_CARRY && flagsQ[FLAG_D] && aluFlags[FLAG_C]);
    cov_push_pull: cover property (accept && opReq.code == OP_PUSH_FLAGS
        ##[1:8] accept && opReq.code == OP_PULL_FLAGS);
    cov_xmode_rmw: cover property (memQ.wr && opQ.code == OP_XOR);
    cov_break_src: cover property (breakTaken && pending != '0);

endmodule : cfd_core

// ===== cfd_pkg.sv
package cfd_pkg;

    // flag word bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_I = 2;
    localparam int FLAG_D = 3;
    localparam int FLAG_B = 4;
    localparam int FLAG_T = 5;
    localparam int FLAG_V = 6;
    localparam int FLAG_N = 7;

    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h04;
    localparam logic [7:0] SP_RST = 8'hFF;
    localparam logic [7:0] VEC_HI_RST = 8'hFF;

    // memory pages used by the core
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [7:0] ZERO_PAGE = 8'h00;

    // break vectoring: source 0 has the highest priority
    localparam int NUM_SRC = 8;
    localparam logic [7:0] VEC_LOW_TOP = 8'hFA;
    localparam logic [7:0] VEC_LOW_BREAK = 8'hDC;

    // register port offsets
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_SP = 8'h04;
    localparam logic [7:0] REG_ACC = 8'h08;
    localparam logic [7:0] REG_IDX = 8'h0C;
    localparam logic [7:0] REG_VEC = 8'h10;

    typedef enum logic [4:0] {
        OP_ADD_CARRY = 5'h00,
        OP_SUB_BORROW = 5'h01,
        OP_AND = 5'h02,
        OP_XOR = 5'h03,
        OP_IOR = 5'h04,
        OP_BIT_SET = 5'h05,
        OP_BIT_CLEAR = 5'h06,
        OP_SHIFT_LEFT = 5'h07,
        OP_SHIFT_RIGHT = 5'h08,
        OP_ROT_LEFT = 5'h09,
        OP_ROT_RIGHT = 5'h0A,
        OP_NIBBLE_ROT = 5'h0B,
        OP_ADD_ONE = 5'h0C,
        OP_SUB_ONE = 5'h0D,
        OP_COMPLEMENT = 5'h0E,
        OP_PUSH_FLAGS = 5'h0F,
        OP_PULL_FLAGS = 5'h10,
        OP_PRODUCT = 5'h11,
        OP_QUOTIENT = 5'h12,
        OP_SW_BREAK = 5'h13,
        OP_CARRY_SET = 5'h14,
        OP_CARRY_CLEAR = 5'h15,
        OP_DECIMAL_ON = 5'h16,
        OP_DECIMAL_OFF = 5'h17,
        OP_XMODE_ON = 5'h18,
        OP_XMODE_OFF = 5'h19,
        OP_LOAD_ACC = 5'h1A,
        OP_LOAD_IDX = 5'h1B,
        OP_IDLE = 5'h1C
    } cfd_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_MODIFY = 2'b10,
        ST_WRITE = 2'b11
    } cfd_state_e;

    typedef struct packed {
        cfd_op_e code;
        logic [7:0] addr;
        logic [7:0] data;
        logic [2:0] bitSel;
    } cfd_op_req_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cfd_mem_cmd_s;

endpackage : cfd_pkg

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    import cfd_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    cfd_op_req_s opReq = '0;
    logic opValid = 1'b0;
    logic opReady, opDone, breakTaken;
    cfd_mem_cmd_s memCmd;
    logic [7:0] memRdata = 8'h00;
    logic [NUM_SRC-1:0] srcReq = '0;
    logic [NUM_SRC-1:0] srcEn = '0;
    logic [15:0] breakVector;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdata, flagsWord, stackPtr, accum, idxX;
    logic [7:0] mem [0:511];
    logic [15:0] wrAddr = 16'h0000;
    logic [7:0] wrData = 8'h00;
    int nBreak = 0;
    int mismatches = 0;
    int n_tests = 0;

    cfd_core i_dut (.mclk(mclk), .rst_n(rst_n), .opReq(opReq),
        .opValid(opValid), .opReady(opReady), .opDone(opDone),
        .memCmd(memCmd), .memRdata(memRdata), .srcReq(srcReq),
        .srcEn(srcEn), .breakVector(breakVector), .breakTaken(breakTaken),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .flagsWord(flagsWord),
        .stackPtr(stackPtr), .accum(accum), .idxX(idxX));

    always #2.5 mclk = ~mclk;

    // memory answers one cycle after rd; idle data toggles so stale reads show
    always @(posedge mclk) begin
        memRdata <= memCmd.rd ? mem[memCmd.addr[8:0]] : ~memRdata;
        if (memCmd.wr) begin
            mem[memCmd.addr[8:0]] <= memCmd.wdata;
            wrAddr <= memCmd.addr;
            wrData <= memCmd.wdata;
        end
    end

    // counts break pulses, so a stuck or missing pulse shows
    always @(posedge mclk) begin
        if (breakTaken === 1'b1)
            nBreak <= nBreak + 1;
    end

    task automatic results();
        if (mismatches == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one operation, waits for the done pulse under a bounded count
    task automatic op(input cfd_op_e c, input logic [7:0] a = 8'h00,
                      input logic [7:0] d = 8'h00, input logic [2:0] b = 3'h0);
        @(posedge mclk);
        opReq <= '{code: c, addr: a, data: d, bitSel: b};
        opValid <= 1'b1;
        @(posedge mclk);
        opValid <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            if (opDone === 1'b1) break;
        end
        chk("opDone", 16'h0001, {15'h0, opDone});
        chk("opReady", 16'h0001, {15'h0, opReady});
    endtask : op

    task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wrReg

    task automatic rdReg(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        chk("regRdata", e, regRdata);
    endtask : rdReg

    // pushes, replaces the stacked byte, pulls it back, then idles
    task automatic setFlags(input logic [7:0] v);
        op(OP_PUSH_FLAGS);
        chk("push addr", 16'h01FF, wrAddr);
        chk("sp after push", 8'hFE, stackPtr);
        mem[9'h1FF] = v;
        op(OP_PULL_FLAGS);
        op(OP_IDLE);
        chk("sp after pull", 8'hFF, stackPtr);
        chk("pulled flags", v, flagsWord);
    endtask : setFlags

    task automatic rmw(input cfd_op_e c, input logic [7:0] a,
                       input logic [7:0] v, input logic [7:0] e,
                       input logic [2:0] b = 3'h0);
        mem[{1'b0, a}] = v;
        op(c, a, 8'h00, b);
        chk("rmw addr", {8'h00, a}, wrAddr);
        chk("rmw data", e, wrData);
    endtask : rmw

    task automatic t_reset();
        chk("reset flags", FLAGS_RST, flagsWord);
        rdReg(REG_FLAGS, 8'h04);
        rdReg(8'h14, 8'h00);
        rdReg(REG_VEC, VEC_HI_RST);
        op(OP_PUSH_FLAGS);
        chk("pushed flags", 8'h04, wrData);
        op(OP_PULL_FLAGS);
        op(OP_IDLE);
    endtask : t_reset

    task automatic t_decimal();
        op(OP_XMODE_OFF);
        op(OP_CARRY_CLEAR);
        op(OP_DECIMAL_ON);
        op(OP_LOAD_ACC, 8'h00, 8'h58);
        op(OP_ADD_CARRY, 8'h00, 8'h47);
        chk("bcd sum", 8'h05, accum);
        chk("bcd carry", 1, flagsWord[FLAG_C]);
        op(OP_IDLE);
        op(OP_CARRY_SET);
        op(OP_LOAD_ACC, 8'h00, 8'h00);
        op(OP_SUB_BORROW, 8'h00, 8'h01);
        chk("bcd diff", 8'h99, accum);
        chk("bcd borrow", 0, flagsWord[FLAG_C]);
        op(OP_IDLE);
        op(OP_CARRY_CLEAR);
        // still decimal: the rmw class must stay binary
        rmw(OP_ROT_LEFT, 8'h20, 8'h40, 8'h80);
        rmw(OP_ROT_RIGHT, 8'h21, 8'h02, 8'h01);
        rmw(OP_ADD_ONE, 8'h22, 8'h79, 8'h7A);
        rmw(OP_SUB_ONE, 8'h23, 8'h00, 8'hFF);
        rmw(OP_COMPLEMENT, 8'h24, 8'h5A, 8'hA5);
        rmw(OP_SHIFT_LEFT, 8'h25, 8'h81, 8'h02);
        rmw(OP_SHIFT_RIGHT, 8'h26, 8'h81, 8'h40);
        rmw(OP_NIBBLE_ROT, 8'h27, 8'h12, 8'h21);
        rmw(OP_BIT_SET, 8'h28, 8'h00, 8'h08, 3'h3);
        rmw(OP_BIT_CLEAR, 8'hFF, 8'hFF, 8'hFE, 3'h0);
        op(OP_DECIMAL_OFF);
    endtask : t_decimal

    task automatic t_xmode();
        op(OP_XMODE_ON);
        op(OP_LOAD_IDX, 8'h00, 8'h30);
        op(OP_LOAD_ACC, 8'h00, 8'h11);
        mem[9'h030] = 8'h0F;
        op(OP_XOR, 8'h00, 8'hFF);
        chk("xmode addr", 16'h0030, wrAddr);
        chk("xmode data", 8'hF0, wrData);
        chk("xmode acc", 8'h11, accum);
        op(OP_AND, 8'h00, 8'h3C);
        chk("xmode and", 8'h30, wrData);
        op(OP_IOR, 8'h00, 8'h05);
        chk("xmode or", 8'h35, wrData);
        op(OP_CARRY_CLEAR);
        op(OP_ADD_CARRY, 8'h00, 8'hD0);
        chk("xmode add", 8'h05, wrData);
        chk("xmode carry", 1, flagsWord[FLAG_C]);
        op(OP_SUB_BORROW, 8'h00, 8'h06);
        chk("xmode sub", 8'hFF, wrData);
        chk("xmode acc kept", 8'h11, accum);
        op(OP_XMODE_OFF);
    endtask : t_xmode

    task automatic t_product();
        op(OP_LOAD_ACC, 8'h00, 8'h12);
        // T and D both set: product must ignore them
        setFlags(8'h6B);
        op(OP_PRODUCT, 8'h00, 8'h10);
        chk("product lo", 8'h20, accum);
        chk("product hi", 8'h01, idxX);
        chk("flags kept", 8'h6B, flagsWord);
        op(OP_QUOTIENT, 8'h00, 8'h06);
        chk("quotient", 16'h0205, {idxX, accum});
        chk("flags kept div", 8'h6B, flagsWord);
        op(OP_QUOTIENT, 8'h00, 8'h00);
        chk("div by zero", 16'h05FF, {idxX, accum});
    endtask : t_product

    task automatic t_break();
        wrReg(REG_VEC, 8'h80);
        rdReg(REG_VEC, 8'h80);
        setFlags(8'h04);
        srcReq <= 8'h04;
        srcEn <= 8'h06;
        op(OP_SW_BREAK);
        chk("break vector", 16'h80F6, breakVector);
        chk("break push b", 1, wrData[FLAG_B]);
        chk("break sets i", 1, flagsWord[FLAG_I]);
        srcEn <= 8'h00;
        op(OP_SW_BREAK);
        chk("plain vector", {8'h80, VEC_LOW_BREAK}, breakVector);
        srcReq <= 8'h05;
        srcEn <= 8'h07;
        op(OP_SW_BREAK);
        chk("top vector", {8'h80, VEC_LOW_TOP}, breakVector);
        chk("break pulses", 3, nBreak);
    endtask : t_break

    // cut a hang short well beyond the couple of hundred cycles expected
    initial begin
        #50000;
        mismatches++;
        results();
    end

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // the stimulus never issues an indirect jump
        t_reset();
        t_decimal();
        t_xmode();
        t_product();
        t_break();
        results();
    end
endmodule : tb
